/* File: hw/wwdt_top.sv */
// Windowed watchdog timer: registers, window check, flags and fault output.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top
    import wwdt_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire wwdt_pkg::wwdt_bus_req_t bus_req,
    output logic [31:0]               rdata,
    input  wire logic                 slow_tick,
    input  wire logic                 debug_state,
    input  wire logic                 idle_mode,
    output logic                      fault,
    output logic                      fault_processor_only,
    output logic                      irq,
    output logic [WWDT_CNT_W-1:0]     count_value
);
    import wwdt_pkg::*;

    // Mode register as written, and its one-time write lock.
    logic [31:0]             mode_r;
    logic [31:0]             mode_nxt;
    logic                    locked_r;
    logic                    locked_nxt;
    wwdt_mode_t              mode;

    // Status flags and the fault level.
    logic                    unf_r;
    logic                    unf_nxt;
    logic                    err_r;
    logic                    err_nxt;
    logic                    fault_r;
    logic                    fault_nxt;
    logic                    proc_r;
    logic                    proc_nxt;

    // Read data register.
    logic [31:0]             rdata_r;
    logic [31:0]             rdata_nxt;

    // Run state, decoded writes and counter handshake.
    wwdt_state_t             state;
    logic                    mode_wr;
    logic                    ctrl_wr;
    logic                    key_ok;
    logic                    restart_req;
    logic                    restart_ok;
    logic                    restart_bad;
    logic                    status_rd;
    logic                    count_tick;
    logic                    underflow;
    logic                    cnt_load;
    logic [WWDT_CNT_W-1:0]   cnt_load_value;
    logic [WWDT_CNT_W-1:0]   count;

    // True when a request addresses the given register.
    function automatic logic hits(input wwdt_bus_req_t req,
                                  input logic [3:0]    off);
        hits = (req.addr == off);
    endfunction : hits

    assign mode = mode_r[WWDT_IDLEHLT_B:0];

    // Decode of the register port.
    assign mode_wr     = bus_req.wr && hits(bus_req, WWDT_OFF_MODE);
    assign ctrl_wr     = bus_req.wr && hits(bus_req, WWDT_OFF_CONTROL);
    assign status_rd   = bus_req.rd && hits(bus_req, WWDT_OFF_STATUS);
    assign key_ok      = bus_req.wdata[WWDT_KEY_LSB +: 8] == WWDT_KEY_VALUE;
    assign restart_req = ctrl_wr && key_ok
                       && bus_req.wdata[WWDT_RESTART_B];

    // The window is open while the count is at or below the delta, so a
    // delta at or above the reload value never refuses a restart.
    assign restart_ok  = restart_req
                       && (count <= mode.restart_window_delta);
    assign restart_bad = restart_req
                       && (count > mode.restart_window_delta);

    // Run state: disable wins, then the debug and idle halts.
    always_comb
    begin
        if (mode.disable_bit)
            state = WWDT_OFF;
        else if ((debug_state && mode.debug_halt)
                 || (idle_mode && mode.idle_halt))
            state = WWDT_HALT;
        else
            state = WWDT_RUN;
    end

    // Underflow is the tick that finds the counter already at zero.
    always_comb
    begin
        case (state)
            WWDT_RUN:  underflow = count_tick && (count == 12'h000);
            WWDT_HALT: underflow = 1'b0;
            WWDT_OFF:  underflow = 1'b0;
            default:   underflow = 1'b0;
        endcase
    end

    // Reload on accepted mode write, good restart or underflow; the new
    // mode value is used at once for the mode write.
    always_comb
    begin
        cnt_load       = 1'b0;
        cnt_load_value = mode.reload_value;
        if (mode_wr && !locked_r)
        begin
            cnt_load       = 1'b1;
            cnt_load_value = bus_req.wdata[WWDT_RELOAD_LSB +: WWDT_CNT_W];
        end
        else if (restart_ok || underflow)
            cnt_load = 1'b1;
    end

    wwdt_prescaler u_prescaler (
        .clock      (clock),
        .reset      (reset),
        .restart    (restart_ok || (mode_wr && !locked_r)),
        .slow_tick  (slow_tick && (state == WWDT_RUN)),
        .count_tick (count_tick)
    );

    wwdt_counter u_counter (
        .clock      (clock),
        .reset      (reset),
        .load       (cnt_load),
        .load_value (cnt_load_value),
        .decrement  (count_tick && (state == WWDT_RUN)),
        .count      (count)
    );

    // Mode register: first write after reset is kept, later ones dropped.
    always_comb
    begin
        mode_nxt   = mode_r;
        locked_nxt = locked_r;
        if (mode_wr && !locked_r)
        begin
            mode_nxt   = bus_req.wdata;
            locked_nxt = 1'b1;
        end
    end

    // Processor reset brings back the power-up mode with the lock open.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mode_r   <= WWDT_MODE_RESET;
            locked_r <= 1'b0;
        end
        else
        begin
            mode_r   <= mode_nxt;
            locked_r <= locked_nxt;
        end
    end

    // Flags and fault: an event in the read cycle survives the clear.
    // A refused restart faults even when the watchdog is disabled.
    always_comb
    begin
        unf_nxt   = unf_r;
        err_nxt   = err_r;
        fault_nxt = fault_r;
        proc_nxt  = proc_r;
        if (status_rd)
        begin
            unf_nxt   = 1'b0;
            err_nxt   = 1'b0;
            fault_nxt = 1'b0;
        end
        if (underflow)
        begin
            unf_nxt = 1'b1;
            if (mode.fault_reset_enable)
            begin
                fault_nxt = 1'b1;
                proc_nxt  = mode.processor_only_reset;
            end
        end
        if (restart_bad)
        begin
            err_nxt   = 1'b1;
            fault_nxt = 1'b1;
            proc_nxt  = mode.processor_only_reset;
        end
    end

    // The reset controller answers a fault with reset, which clears all.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            unf_r   <= 1'b0;
            err_r   <= 1'b0;
            fault_r <= 1'b0;
            proc_r  <= 1'b0;
        end
        else
        begin
            unf_r   <= unf_nxt;
            err_r   <= err_nxt;
            fault_r <= fault_nxt;
            proc_r  <= proc_nxt;
        end
    end

    // Read data: control and unmapped offsets read as zero.
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        if (bus_req.rd)
        begin
            if (hits(bus_req, WWDT_OFF_MODE))
                rdata_nxt = mode_r;
            else if (hits(bus_req, WWDT_OFF_STATUS))
            begin
                rdata_nxt[WWDT_UNF_B] = unf_r;
                rdata_nxt[WWDT_ERR_B] = err_r;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= rdata_nxt;
    end

    // Outputs; the interrupt follows the flags and the enable bit.
    assign rdata                = rdata_r;
    assign fault                = fault_r;
    assign fault_processor_only = proc_r;
    assign irq = mode.fault_irq_enable && (unf_r || err_r);
    assign count_value          = count;

    mode_lock_a: assert property (@(posedge clock) disable iff (reset)
        locked_r && mode_wr |=> mode_r == $past(mode_r))
        else $error("locked mode register changed on a write");

    reset_mode_a: assert property (@(posedge clock)
        reset |=> mode_r == 32'h3fff2fff && count == 12'hfff && !fault)
        else $error("reset did not restore initial watchdog state");

    mode_reload_a: assert property (@(posedge clock) disable iff (reset)
        mode_wr && !locked_r |=>
            count == $past(bus_req.wdata[11:0]))
        else $error("accepted mode write did not reload the counter");

    restart_load_a: assert property (@(posedge clock) disable iff (reset)
        restart_ok |=> count == mode.reload_value && !$rose(err_r))
        else $error("valid restart did not reload the counter");

    bad_key_a: assert property (@(posedge clock) disable iff (reset)
        ctrl_wr && !key_ok && !underflow |=> $stable(err_r) && $stable(mode_r))
        else $error("write with a wrong key had an effect");

    window_err_a: assert property (@(posedge clock) disable iff (reset)
        restart_bad |=> err_r && fault)
        else $error("restart outside the window did not fault");

    unf_flag_a: assert property (@(posedge clock) disable iff (reset)
        underflow |=> unf_r && (fault == ($past(mode.fault_reset_enable)
                                          || $past(restart_bad)
                                          || ($past(fault_r)
                                              && !$past(status_rd)))))
        else $error("underflow did not set its flag or fault");

    irq_gate_a: assert property (@(posedge clock) disable iff (reset)
        !mode.fault_irq_enable |-> !irq)
        else $error("interrupt raised with its enable clear");

    read_clear_a: assert property (@(posedge clock) disable iff (reset)
        status_rd && !underflow && !restart_bad |=> !fault && !unf_r && !err_r)
        else $error("status read did not clear flags and fault");

    halt_stop_a: assert property (@(posedge clock) disable iff (reset)
        state != WWDT_RUN && !cnt_load |=> count == $past(count))
        else $error("counter moved while halted or disabled");

    fault_hold_a: assert property (@(posedge clock) disable iff (reset)
        fault && !status_rd |=> fault)
        else $error("fault dropped without a status read");

endmodule : wwdt_top
`default_nettype wire

/* File: hw/wwdt_pkg.sv */
// Package with register map, field layout and reset values of the watchdog.
package wwdt_pkg;

    // Register byte offsets on the register port.
    localparam logic [3:0] WWDT_OFF_CONTROL = 4'h0;
    localparam logic [3:0] WWDT_OFF_MODE    = 4'h4;
    localparam logic [3:0] WWDT_OFF_STATUS  = 4'h8;

    // Counter and prescaler sizes.
    localparam int         WWDT_CNT_W      = 12;
    localparam int         WWDT_PRE_W      = 7;
    localparam logic [6:0] WWDT_PRE_LAST   = 7'h7f;

    // Control register layout and the fixed key.
    localparam int         WWDT_KEY_LSB    = 24;
    localparam logic [7:0] WWDT_KEY_VALUE  = 8'ha5;
    localparam int         WWDT_RESTART_B  = 0;

    // Mode register field positions.
    localparam int WWDT_RELOAD_LSB   = 0;
    localparam int WWDT_FIEN_B       = 12;
    localparam int WWDT_RSTEN_B      = 13;
    localparam int WWDT_PROC_B       = 14;
    localparam int WWDT_DIS_B        = 15;
    localparam int WWDT_DELTA_LSB    = 16;
    localparam int WWDT_DBGHLT_B     = 28;
    localparam int WWDT_IDLEHLT_B    = 29;

    // Mode register reset value and status bit positions.
    localparam logic [31:0] WWDT_MODE_RESET = 32'h3fff2fff;
    localparam int          WWDT_UNF_B      = 0;
    localparam int          WWDT_ERR_B      = 1;

    // Register port request, one struct per cycle.
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wwdt_bus_req_t;

    // Decoded mode register contents.
    typedef struct packed {
        logic                  idle_halt;
        logic                  debug_halt;
        logic [WWDT_CNT_W-1:0] restart_window_delta;
        logic                  disable_bit;
        logic                  processor_only_reset;
        logic                  fault_reset_enable;
        logic                  fault_irq_enable;
        logic [WWDT_CNT_W-1:0] reload_value;
    } wwdt_mode_t;

    // Run, halt and off (disabled) conditions seen by the core.
    typedef enum logic [2:0] {
        WWDT_RUN  = 3'b001,
        WWDT_HALT = 3'b010,
        WWDT_OFF  = 3'b100
    } wwdt_state_t;

endpackage : wwdt_pkg

/* File: hw/wwdt_prescaler.sv */
// Divide-by-128 prescaler that turns slow clock ticks into counter ticks.
`timescale 1ns/1ps
`default_nettype none
module wwdt_prescaler
    import wwdt_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic restart,
    input  wire logic slow_tick,
    output logic      count_tick
);
    logic [WWDT_PRE_W-1:0] div_r;
    logic [WWDT_PRE_W-1:0] div_nxt;

    // A restart clears the divider so the next period is a full one.
    always_comb
    begin
        div_nxt = div_r;
        if (restart)
            div_nxt = '0;
        else if (slow_tick)
            div_nxt = div_r + 7'h01;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            div_r <= '0;
        else
            div_r <= div_nxt;
    end

    // One tick every 128 slow clock ticks; the tick is a strobe, not a level.
    assign count_tick = slow_tick && !restart && (div_r == WWDT_PRE_LAST);

    // The divider wraps to zero exactly on the tick.
    pre_wrap_a: assert property (@(posedge clock) disable iff (reset)
        count_tick |=> div_r == 7'h00)
        else $error("prescaler did not wrap after its tick");

endmodule : wwdt_prescaler
`default_nettype wire

/* File: hw/wwdt_counter.sv */
// Twelve-bit down counter with load priority over decrement.
`timescale 1ns/1ps
`default_nettype none
module wwdt_counter
    import wwdt_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  load,
    input  wire logic [WWDT_CNT_W-1:0] load_value,
    input  wire logic                  decrement,
    output logic [WWDT_CNT_W-1:0]      count
);
    logic [WWDT_CNT_W-1:0] count_r;
    logic [WWDT_CNT_W-1:0] count_nxt;

    // Load wins so a restart in a tick cycle is never lost.
    always_comb
    begin
        count_nxt = count_r;
        if (load)
            count_nxt = load_value;
        else if (decrement)
            count_nxt = count_r - 12'h001;
    end

    // Reset loads the full count so the watchdog runs from power-up.
    always_ff @(posedge clock)
    begin
        if (reset)
            count_r <= 12'hfff;
        else
            count_r <= count_nxt;
    end

    assign count = count_r;

    cnt_load_a: assert property (@(posedge clock) disable iff (reset)
        load |=> count_r == $past(load_value))
        else $error("counter did not take the load value");

endmodule : wwdt_counter
`default_nettype wire

/* File: sim/wwdt_bench.sv */
// Self-checking bench for the windowed watchdog over its register port.
`timescale 1ns/1ps
`default_nettype none
module wwdt_bench;
    import wwdt_pkg::*;

    // The whole sequence is under 6000 cycles, so this only catches hangs.
    localparam int          TIMEOUT_CYCLES = 20000;
    localparam logic [31:0] MODE_A         = 32'h30037005;
    localparam logic [31:0] MODE_B         = 32'h0000a002;
    localparam logic [31:0] MODE_C         = 32'h00000003;

    logic                  clock;
    logic                  reset;
    wwdt_bus_req_t         bus_req;
    logic [31:0]           rdata;
    logic                  slow_tick;
    logic                  debug_state;
    logic                  idle_mode;
    logic                  fault;
    logic                  fault_processor_only;
    logic                  irq;
    logic [WWDT_CNT_W-1:0] count_value;
    int                    errors;
    int                    samples_checked;
    int                    cycles = 0;

    wwdt_top u_dut (
        .clock                (clock),
        .reset                (reset),
        .bus_req              (bus_req),
        .rdata                (rdata),
        .slow_tick            (slow_tick),
        .debug_state          (debug_state),
        .idle_mode            (idle_mode),
        .fault                (fault),
        .fault_processor_only (fault_processor_only),
        .irq                  (irq),
        .count_value          (count_value)
    );

    // Free-running clock at 40 MHz.
    always #12.5 clock = ~clock;

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Cuts a hang short and reports it as a mismatch.
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES)
        begin
            errors++;
            summarize();
        end
    end

    // Compare tasks, one per width of result.
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic check12(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check12

    task automatic check1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check1

    // One-cycle write; returns mid-cycle after the edge that took it.
    task automatic bus_write(input logic [3:0] addr, input logic [31:0] data);
        @(posedge clock);
        bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
        @(negedge clock);
    endtask : bus_write

    // One-cycle read; read data exist only in the following cycle.
    task automatic bus_read(input logic [3:0] addr, input logic [31:0] exp);
        @(posedge clock);
        bus_req <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        @(negedge clock);
        check32(rdata, exp);
    endtask : bus_read

    // Control write with restart set and the given key.
    task automatic restart(input logic [7:0] key);
        bus_write(WWDT_OFF_CONTROL, {key, 23'h0, 1'b1});
    endtask : restart

    // Slow clock pulses two cycles apart, then time for the counter to settle.
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clock);
            slow_tick <= 1'b1;
            @(posedge clock);
            slow_tick <= 1'b0;
        end
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask : ticks

    // Expected state of the outputs right after any reset.
    task automatic check_reset_state;
        check12(count_value, 12'hfff);
        check1(fault, 1'b0);
        check1(irq, 1'b0);
        check1(fault_processor_only, 1'b0);
        bus_read(WWDT_OFF_MODE, 32'h3fff2fff);
        bus_read(WWDT_OFF_STATUS, 32'h0);
    endtask : check_reset_state

    // Main sequence of tests.
    initial
    begin
        clock = 1'b0;
        reset = 1'b1;
        bus_req = '0;
        slow_tick = 1'b0;
        debug_state = 1'b0;
        idle_mode = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check_reset_state();
        bus_read(WWDT_OFF_CONTROL, 32'h0);
        bus_read(4'hc, 32'h0);
        // Exactly 128 slow pulses make one decrement.
        ticks(127);
        check12(count_value, 12'hfff);
        ticks(1);
        check12(count_value, 12'hffe);
        restart(8'h5a);
        check12(count_value, 12'hffe);
        // Defaults put delta equal to reload, so no window error.
        restart(WWDT_KEY_VALUE);
        check12(count_value, 12'hfff);
        check1(fault, 1'b0);
        // A restart must clear the partly counted prescaler.
        ticks(100);
        restart(WWDT_KEY_VALUE);
        ticks(127);
        check12(count_value, 12'hfff);
        ticks(1);
        check12(count_value, 12'hffe);
        // First mode write loads at once; a second one is ignored.
        bus_write(WWDT_OFF_MODE, MODE_A);
        check12(count_value, 12'h005);
        bus_write(WWDT_OFF_MODE, 32'h00000123);
        bus_read(WWDT_OFF_MODE, MODE_A);
        check12(count_value, 12'h005);
        // Restart above the window raises error and a held fault.
        restart(WWDT_KEY_VALUE);
        check1(fault, 1'b1);
        check1(irq, 1'b1);
        check1(fault_processor_only, 1'b1);
        check12(count_value, 12'h005);
        repeat (10) @(posedge clock);
        @(negedge clock);
        check1(fault, 1'b1);
        bus_read(WWDT_OFF_STATUS, 32'h2);
        check1(fault, 1'b0);
        check1(irq, 1'b0);
        // Both halt inputs freeze the counter when their bits are set.
        @(posedge clock);
        debug_state <= 1'b1;
        ticks(128);
        check12(count_value, 12'h005);
        @(posedge clock);
        debug_state <= 1'b0;
        idle_mode <= 1'b1;
        ticks(128);
        check12(count_value, 12'h005);
        @(posedge clock);
        idle_mode <= 1'b0;
        ticks(256);
        check12(count_value, 12'h003);
        restart(WWDT_KEY_VALUE);
        check12(count_value, 12'h005);
        check1(fault, 1'b0);
        // Underflow reloads, sets its flag and faults.
        ticks(640);
        check12(count_value, 12'h000);
        check1(fault, 1'b0);
        ticks(128);
        check12(count_value, 12'h005);
        check1(fault, 1'b1);
        check1(irq, 1'b1);
        // A reset with the fault up restores every initial value.
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check_reset_state();
        // Disabled: no counting, yet window errors still fault.
        bus_write(WWDT_OFF_MODE, MODE_B);
        bus_read(WWDT_OFF_MODE, MODE_B);
        ticks(384);
        check12(count_value, 12'h002);
        bus_read(WWDT_OFF_STATUS, 32'h0);
        restart(WWDT_KEY_VALUE);
        check1(fault, 1'b1);
        check1(fault_processor_only, 1'b0);
        check1(irq, 1'b0);
        bus_read(WWDT_OFF_STATUS, 32'h2);
        check1(fault, 1'b0);
        // Halt bits clear: debug and idle leave the counter running.
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        bus_write(WWDT_OFF_MODE, MODE_C);
        @(posedge clock);
        debug_state <= 1'b1;
        idle_mode <= 1'b1;
        ticks(128);
        check12(count_value, 12'h002);
        ticks(256);
        check12(count_value, 12'h000);
        // Underflow with the reset enable clear sets the flag only.
        ticks(128);
        check12(count_value, 12'h003);
        check1(fault, 1'b0);
        check1(irq, 1'b0);
        bus_read(WWDT_OFF_STATUS, 32'h1);
        summarize();
    end

endmodule : wwdt_bench
`default_nettype wire
